// ### inc/dram_sequencer_map.svh
// register map, field positions, codes and timing counts of the dram sequencer
// Overview of operation
// - normal burst: five clocks, then four each
// - slower timing register settings stretch normal transfers
// - normal burst: negate ack and ras, precharge, row again
// - capture and decode on sampled transfer start
// - drive row address and write strobe next
// - ras on falling edge, then column, ack negated
// - cas per lane: both for 16-bit, one for 8-bit
// - ack asserted on edge after cas
// - normal: ras, cas, ack end together
// - secondary beats use incremented column address
// - release address, then ack one clock later
// - page mode: hold ras, precharge cas, next column
// - page burst: five then two clocks each
// - page burst closes row; nonburst runs normal
// - fast page bank acts as burst page
// - burst when operand wider than port width
// - access-type mask bits ignored for hit
// - unavailable upper address bits forced zero for hit
// - read and write share strobe timing
// - address drive bit clear leaves bus undriven
// - normal secondary beat waits for row precharge
`ifndef DRAM_SEQUENCER_MAP_SVH
`define DRAM_SEQUENCER_MAP_SVH
// word indexes on the register bus
`define REG_TIMING 4'h0
`define REG_PINS 4'h1
`define REG_BASE0 4'h2
`define REG_MASK0 4'h3
`define REG_CTRL0 4'h4
`define REG_BASE1 4'h5
`define REG_MASK1 4'h6
`define REG_CTRL1 4'h7
`define REG_STATUS 4'h8
// timing register fields
`define TIM_DRIVE 15
`define TIM_RCD 12
`define TIM_RP_HI 6
`define TIM_RP_LO 5
`define TIM_CASW 3
`define TIM_CP 1
// bank control fields and codes
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0
`define CTRL_PORT_HI 3
`define CTRL_PORT_LO 2
`define MODE_OFF 2'h0
`define MODE_BURST_PAGE 2'h2
`define MODE_FAST_PAGE 2'h3
`define PORT_32 2'h0
`define PORT_8 2'h1
`define PORT_16 2'h2
`define SIZE_LONG 2'h0
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h2
`define SIZE_LINE 2'h3
// hit compare covers address bits from this one upward
`define HIT_LSB 17
// reset values
`define TIMING_RST 16'h0000
`define PINS_RST 4'h0
`define BASE_RST 32'h00000000
`define MASK_RST 32'h00000000
`define CTRL_RST 8'h00
// fastest subtransfer lengths in clocks
`define FIRST_BEAT_CLKS 5
`define NORMAL_NEXT_CLKS 4
`define PAGE_NEXT_CLKS 2
`endif

// ### inc/dram_sequencer_pkg.sv
// types shared by the dram sequencer
package dram_sequencer_pkg;
    typedef enum logic [2:0] {S_IDLE, S_DECODE, S_ROW, S_COL, S_ACK, S_PRECH, S_CPRE, S_TAREL} seq_state_e;
    typedef struct packed {
        logic [27:0] addr;
        logic rw;
        logic [1:0] size;
        logic start_n;
    } ext_req_s;
    typedef struct packed {
        logic [27:0] addr;
        logic [27:0] addr_oe;
        logic ta_n;
        logic ta_oe;
        logic we_n;
    } pin_out_s;
    typedef struct packed {
        ext_req_s sync1;
        ext_req_s sync2;
        seq_state_e state;
        logic [27:0] cur;
        logic rw;
        logic [1:0] size;
        logic [1:0] lane;
        logic [1:0] port;
        logic page;
        logic [4:0] beats;
        logic [1:0] wait_cnt;
        pin_out_s pins;
        logic ras_p;
        logic ras_fire;
        logic cas_p;
        logic cas_fire;
        logic [15:0] timing;
        logic [3:0] par;
        logic [1:0][31:0] base;
        logic [1:0][31:0] mask;
        logic [1:0][7:0] ctrl;
        logic waitreq;
        logic [31:0] rdata;
    } seq_reg_s;
endpackage

// ### src/dram_sequencer.sv
// dram sequencer for external bus master transfers with avalon register slave
//
// The Avalon-MM register port and the register addresses were decided locally.
`include "dram_sequencer_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dram_sequencer (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // register bus
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // external master side
    input wire logic [27:0] ext_addr_in,
    input wire logic ext_read_write_in,
    input wire logic [1:0] transfer_size_code_in,
    input wire logic transfer_start_n_in,
    // dram and shared bus drive
    output logic [27:0] addr_out,
    output logic [27:0] addr_oe_out,
    output logic transfer_ack_n_out,
    output logic transfer_ack_oe_out,
    output logic ras_n_out,
    output logic [1:0] cas_n_out,
    output logic dram_write_strobe_n_out
);

    ////////////////////////////////////////////////////////////////////////
    // state and helpers

    dram_sequencer_pkg::seq_reg_s st;
    dram_sequencer_pkg::seq_reg_s next_st;
    logic ras_n_half;
    logic cas_n_half;
    logic ras_on;
    logic cas_on;
    logic [1:0] bank_hit;
    logic hit;
    logic sel;
    logic [31:0] eff_addr;

    // byte-enable merge for register writes
    function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // log2 of port width in bytes
    function automatic logic [1:0] port_shift(input logic [1:0] port);
        case (port)
            `PORT_8: port_shift = 2'h0;
            `PORT_16: port_shift = 2'h1;
            default: port_shift = 2'h2;
        endcase
    endfunction

    // operand size in bytes
    function automatic logic [4:0] size_bytes(input logic [1:0] size);
        case (size)
            `SIZE_BYTE: size_bytes = 5'h01;
            `SIZE_WORD: size_bytes = 5'h02;
            `SIZE_LINE: size_bytes = 5'h10;
            default: size_bytes = 5'h04;
        endcase
    endfunction

    // column address bits 8..0 multiplexed onto pins 8..0 and again onto pins 17..9
    function automatic logic [27:0] col_bus(input logic [27:0] a);
        col_bus = {10'h000, a[8:0], a[8:0]};
    endfunction

    // strobes are two-edge: a rising-edge toggle and a falling-edge toggle
    assign ras_on = st.ras_p ^ ras_n_half;
    assign cas_on = st.cas_p ^ cas_n_half;
    assign ras_n_out = ~ras_on;
    assign cas_n_out = ~({2{cas_on}} & st.lane);

    ////////////////////////////////////////////////////////////////////////
    // bank hit decode

    // unavailable upper bits count as zero when deciding a hit
    assign eff_addr = {4'h0, st.cur[27:24] & st.par, st.cur[23:0]};

    // one compare per bank; the low mask bits (access types) are never looked at
    genvar gb;
    generate
        for (gb = 0; gb < 2; gb++) begin : g_bank
            assign bank_hit[gb] = (st.ctrl[gb][`CTRL_MODE_HI:`CTRL_MODE_LO] != `MODE_OFF) &&
                ((((eff_addr ^ st.base[gb]) & ~st.mask[gb]) >> `HIT_LSB) == 32'h0);
        end
    endgenerate
    assign hit = |bank_hit;
    assign sel = ~bank_hit[0];

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic [1:0] mode;
        logic [1:0] port;
        logic [4:0] nbeats;
        logic [27:0] inc_addr;
        logic [27:0] oe_mask;
        logic [31:0] tim_new;
        mode = st.ctrl[sel][`CTRL_MODE_HI:`CTRL_MODE_LO];
        port = st.ctrl[sel][`CTRL_PORT_HI:`CTRL_PORT_LO];
        nbeats = size_bytes(st.size) >> port_shift(port);
        inc_addr = st.cur + (28'h1 << port_shift(st.port));
        // address pins given another function stay undriven
        oe_mask = st.timing[`TIM_DRIVE] ? {st.par, 24'hffffff} : 28'h0;
        // timing register is 16 bits wide; only the low two bytes land
        tim_new = merge32({16'h0000, st.timing}, avs_writedata_in, avs_byteenable_in);
        next_st = st;
        // pins cross into this clock through two stages
        next_st.sync1 = {ext_addr_in, ext_read_write_in, transfer_size_code_in, transfer_start_n_in};
        next_st.sync2 = st.sync1;
        next_st.ras_fire = 1'b0;
        next_st.cas_fire = 1'b0;
        next_st.waitreq = 1'b1;

        // register bus: answer one cycle after the request appears
        if ((avs_read_in || avs_write_in) && st.waitreq) begin
            next_st.waitreq = 1'b0;
            case (avs_address_in)
                `REG_TIMING: next_st.rdata = {16'h0000, st.timing};
                `REG_PINS: next_st.rdata = {28'h0, st.par};
                `REG_BASE0: next_st.rdata = st.base[0];
                `REG_MASK0: next_st.rdata = st.mask[0];
                `REG_CTRL0: next_st.rdata = {24'h0, st.ctrl[0]};
                `REG_BASE1: next_st.rdata = st.base[1];
                `REG_MASK1: next_st.rdata = st.mask[1];
                `REG_CTRL1: next_st.rdata = {24'h0, st.ctrl[1]};
                `REG_STATUS: next_st.rdata = {28'h0, st.state, st.state != dram_sequencer_pkg::S_IDLE};
                default: next_st.rdata = 32'h0;
            endcase
        end
        // writes land on the edge where waitrequest is seen low
        if (avs_write_in && !st.waitreq) begin
            case (avs_address_in)
                `REG_TIMING: next_st.timing = tim_new[15:0];
                `REG_PINS: next_st.par = avs_byteenable_in[0] ? avs_writedata_in[3:0] : st.par;
                `REG_BASE0: next_st.base[0] = merge32(st.base[0], avs_writedata_in, avs_byteenable_in);
                `REG_MASK0: next_st.mask[0] = merge32(st.mask[0], avs_writedata_in, avs_byteenable_in);
                `REG_CTRL0: next_st.ctrl[0] = avs_byteenable_in[0] ? avs_writedata_in[7:0] : st.ctrl[0];
                `REG_BASE1: next_st.base[1] = merge32(st.base[1], avs_writedata_in, avs_byteenable_in);
                `REG_MASK1: next_st.mask[1] = merge32(st.mask[1], avs_writedata_in, avs_byteenable_in);
                `REG_CTRL1: next_st.ctrl[1] = avs_byteenable_in[0] ? avs_writedata_in[7:0] : st.ctrl[1];
                default: next_st.timing = st.timing;
            endcase
        end

        // transfer sequencing; read and write run the same strobe pattern
        case (st.state)
            dram_sequencer_pkg::S_IDLE: begin
                // start is taken once; later beats need no new start
                if (!st.sync2.start_n) begin
                    next_st.cur = st.sync2.addr;
                    next_st.rw = st.sync2.rw;
                    next_st.size = st.sync2.size;
                    next_st.state = dram_sequencer_pkg::S_DECODE;
                end
            end
            dram_sequencer_pkg::S_DECODE: begin
                // a miss touches no dram pin and no shared bus line
                if (!hit) begin
                    next_st.state = dram_sequencer_pkg::S_IDLE;
                end else begin
                    // the master has let go of the address by now
                    next_st.pins.addr = st.cur;
                    next_st.pins.addr_oe = oe_mask;
                    next_st.pins.we_n = st.rw;
                    next_st.ras_fire = 1'b1;
                    next_st.port = port;
                    next_st.beats = (nbeats == 5'h0) ? 5'h1 : nbeats;
                    next_st.page = (mode == `MODE_BURST_PAGE || mode == `MODE_FAST_PAGE) && nbeats > 5'h1;
                    next_st.lane = (port == `PORT_8) ? 2'b01 : 2'b11;
                    next_st.wait_cnt = {1'b0, st.timing[`TIM_RCD]};
                    next_st.state = dram_sequencer_pkg::S_ROW;
                end
            end
            dram_sequencer_pkg::S_ROW: begin
                if (st.wait_cnt == 2'h0) begin
                    next_st.pins.addr = col_bus(st.cur);
                    next_st.pins.ta_oe = 1'b1;
                    next_st.pins.ta_n = 1'b1;
                    next_st.cas_fire = 1'b1;
                    next_st.wait_cnt = {1'b0, st.timing[`TIM_CASW]};
                    next_st.state = dram_sequencer_pkg::S_COL;
                end else begin
                    next_st.wait_cnt = st.wait_cnt - 2'h1;
                end
            end
            dram_sequencer_pkg::S_COL: begin
                if (st.wait_cnt == 2'h0) begin
                    next_st.pins.ta_n = 1'b0;
                    next_st.state = dram_sequencer_pkg::S_ACK;
                end else begin
                    next_st.wait_cnt = st.wait_cnt - 2'h1;
                end
            end
            dram_sequencer_pkg::S_ACK: begin
                // every beat ends with cas and ack negated
                next_st.pins.ta_n = 1'b1;
                next_st.cas_p = ~st.cas_p;
                if (st.beats == 5'h1) begin
                    // last beat: close the row and let go of the address
                    next_st.ras_p = ~st.ras_p;
                    next_st.pins.addr_oe = 28'h0;
                    next_st.state = dram_sequencer_pkg::S_TAREL;
                end else if (st.page) begin
                    // row stays open; next column goes out at once
                    next_st.beats = st.beats - 5'h1;
                    next_st.cur = inc_addr;
                    next_st.pins.addr = col_bus(inc_addr);
                    if (!st.timing[`TIM_CP]) begin
                        next_st.cas_fire = 1'b1;
                        next_st.wait_cnt = {1'b0, st.timing[`TIM_CASW]};
                        next_st.state = dram_sequencer_pkg::S_COL;
                    end else begin
                        next_st.wait_cnt = 2'h0;
                        next_st.state = dram_sequencer_pkg::S_CPRE;
                    end
                end else begin
                    // row reopened only after precharge: 1.5 clocks at the fastest
                    next_st.beats = st.beats - 5'h1;
                    next_st.cur = inc_addr;
                    next_st.ras_p = ~st.ras_p;
                    next_st.pins.addr = inc_addr;
                    next_st.wait_cnt = st.timing[`TIM_RP_HI:`TIM_RP_LO];
                    next_st.state = dram_sequencer_pkg::S_PRECH;
                end
            end
            dram_sequencer_pkg::S_PRECH: begin
                if (st.wait_cnt == 2'h0) begin
                    next_st.ras_fire = 1'b1;
                    next_st.wait_cnt = {1'b0, st.timing[`TIM_RCD]};
                    next_st.state = dram_sequencer_pkg::S_ROW;
                end else begin
                    next_st.wait_cnt = st.wait_cnt - 2'h1;
                end
            end
            dram_sequencer_pkg::S_CPRE: begin
                if (st.wait_cnt == 2'h0) begin
                    next_st.cas_fire = 1'b1;
                    next_st.wait_cnt = {1'b0, st.timing[`TIM_CASW]};
                    next_st.state = dram_sequencer_pkg::S_COL;
                end else begin
                    next_st.wait_cnt = st.wait_cnt - 2'h1;
                end
            end
            dram_sequencer_pkg::S_TAREL: begin
                // ack released a clock after the address
                next_st.pins.ta_oe = 1'b0;
                next_st.state = dram_sequencer_pkg::S_IDLE;
            end
            default: begin
                next_st.state = dram_sequencer_pkg::S_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st <= '0;
            st.sync1.start_n <= 1'b1;
            st.sync2.start_n <= 1'b1;
            st.state <= dram_sequencer_pkg::S_IDLE;
            st.pins.ta_n <= 1'b1;
            st.pins.we_n <= 1'b1;
            st.timing <= `TIMING_RST;
            st.par <= `PINS_RST;
            st.base <= {2{`BASE_RST}};
            st.mask <= {2{`MASK_RST}};
            st.ctrl <= {2{`CTRL_RST}};
            st.waitreq <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // falling-edge halves of ras and cas; they only follow the fire requests
    always_ff @(negedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ras_n_half <= 1'b0;
            cas_n_half <= 1'b0;
        end else begin
            ras_n_half <= ras_n_half ^ st.ras_fire;
            cas_n_half <= cas_n_half ^ st.cas_fire;
        end
    end

    assign avs_readdata_out = st.rdata;
    assign avs_waitrequest_out = st.waitreq;
    assign addr_out = st.pins.addr;
    assign addr_oe_out = st.pins.addr_oe;
    assign transfer_ack_n_out = st.pins.ta_n;
    assign transfer_ack_oe_out = st.pins.ta_oe;
    assign dram_write_strobe_n_out = st.pins.we_n;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    property p_capture;
        @(posedge mclk_in) disable iff (sys_rst_in)
        st.state == dram_sequencer_pkg::S_IDLE && !st.sync2.start_n
            |=> st.state == dram_sequencer_pkg::S_DECODE && st.cur == $past(st.sync2.addr);
    endproperty
    a_capture: assert property (p_capture) else $error("start not captured");

    property p_row_drive;
        @(posedge mclk_in) disable iff (sys_rst_in)
        st.state == dram_sequencer_pkg::S_DECODE && hit
            |-> !ras_on ##1 st.pins.addr == $past(st.cur) && st.pins.we_n == $past(st.rw) && ras_on;
    endproperty
    a_row_drive: assert property (p_row_drive) else $error("row phase wrong");

    property p_col;
        @(posedge mclk_in) disable iff (sys_rst_in)
        st.state == dram_sequencer_pkg::S_ROW && st.wait_cnt == 2'h0
            |=> st.pins.ta_oe && st.pins.ta_n && st.pins.addr == col_bus(st.cur) ##1 cas_on;
    endproperty
    a_col: assert property (p_col) else $error("column phase wrong");

    // sampled on the falling edge: a page beat may refire cas half a clock after it ends
    property p_ack_end;
        @(negedge mclk_in) disable iff (sys_rst_in)
        st.pins.ta_oe && !st.pins.ta_n |-> cas_on ##1 st.pins.ta_n && !cas_on;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("beat did not end");

    property p_normal_pre;
        @(posedge mclk_in) disable iff (sys_rst_in)
        st.state == dram_sequencer_pkg::S_ACK && !st.page && st.beats != 5'h1
            |=> !ras_on && st.pins.ta_n && st.pins.addr == st.cur && st.state == dram_sequencer_pkg::S_PRECH;
    endproperty
    a_normal_pre: assert property (p_normal_pre) else $error("precharge too short");

    property p_page_hold;
        @(negedge mclk_in) disable iff (sys_rst_in)
        st.state == dram_sequencer_pkg::S_ACK && st.page && st.beats != 5'h1
            |=> ras_on && !cas_on && st.pins.ta_n && st.pins.addr == col_bus(st.cur);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("page row dropped");

    property p_release;
        @(posedge mclk_in) disable iff (sys_rst_in)
        st.state == dram_sequencer_pkg::S_ACK && st.beats == 5'h1
            |=> st.pins.addr_oe == 28'h0 && st.pins.ta_oe && !ras_on ##1 !st.pins.ta_oe;
    endproperty
    a_release: assert property (p_release) else $error("release order wrong");

    property p_nohit;
        @(posedge mclk_in) disable iff (sys_rst_in)
        st.state == dram_sequencer_pkg::S_DECODE && !hit
            |=> st.state == dram_sequencer_pkg::S_IDLE && st.pins.addr_oe == 28'h0 && !st.pins.ta_oe && !ras_on;
    endproperty
    a_nohit: assert property (p_nohit) else $error("miss drove pins");

    property p_bus_answer;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (avs_read_in || avs_write_in) && st.waitreq |=> !st.waitreq ##1 st.waitreq;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    property p_cov_normal;
        @(posedge mclk_in) disable iff (sys_rst_in) st.state == dram_sequencer_pkg::S_PRECH;
    endproperty
    c_cov_normal: cover property (p_cov_normal);

    property p_cov_page;
        @(posedge mclk_in) disable iff (sys_rst_in)
        st.state == dram_sequencer_pkg::S_ACK && st.page && st.beats != 5'h1;
    endproperty
    c_cov_page: cover property (p_cov_page);

    property p_cov_miss;
        @(posedge mclk_in) disable iff (sys_rst_in) st.state == dram_sequencer_pkg::S_DECODE && !hit;
    endproperty
    c_cov_miss: cover property (p_cov_miss);

endmodule
`default_nettype wire

// ### testbench/ext_master_model.sv
// external bus master model that starts transfers on the shared bus
`timescale 1ns/1ps
`default_nettype none
module ext_master_model (
    // clock and command from the bench
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [27:0] addr_in,
    input wire logic rw_in,
    input wire logic [1:0] size_in,
    // shared bus
    output logic [27:0] addr_out,
    output logic rw_out,
    output logic [1:0] size_out,
    output logic start_n_out
);
    // idle bus at time zero
    initial begin
        addr_out = 28'h0;
        rw_out = 1'b1;
        size_out = 2'h0;
        start_n_out = 1'b1;
    end
    // one start per burst; the inverted address stands in for a released bus
    always @(posedge clk_in) begin
        if (go_in) begin
            addr_out <= addr_in;
            rw_out <= rw_in; // write data lanes stay with the master, none modelled here
            size_out <= size_in;
            start_n_out <= 1'b0;
        end else if (!start_n_out) begin
            start_n_out <= 1'b1;
            addr_out <= ~addr_out;
        end
    end
endmodule
`default_nettype wire

// ### testbench/dram_sequencer_tb.sv
// self-checking bench for the dram sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module dram_sequencer_tb;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, go = 1'b0, m_rw = 1'b1, x_rw, x_st;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [27:0] m_a = 28'h0, x_a, a_o, a_oe;
    logic [1:0] m_sz = 2'h0, x_sz, cas;
    logic wait_o, ack_n, ack_oe, ras, we_n;
    int num_errors = 0, n_checks = 0;
    always #4 clk = ~clk;
    ext_master_model ext_master_model_i (.clk_in(clk), .go_in(go), .addr_in(m_a), .rw_in(m_rw), .size_in(m_sz),
        .addr_out(x_a), .rw_out(x_rw), .size_out(x_sz), .start_n_out(x_st));
    dram_sequencer dram_sequencer_i (.mclk_in(clk), .sys_rst_in(rst), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wait_o), .ext_addr_in(x_a), .ext_read_write_in(x_rw), .transfer_size_code_in(x_sz),
        .transfer_start_n_in(x_st), .addr_out(a_o), .addr_oe_out(a_oe), .transfer_ack_n_out(ack_n),
        .transfer_ack_oe_out(ack_oe), .ras_n_out(ras), .cas_n_out(cas), .dram_write_strobe_n_out(we_n));
    ////////////////////////////////////////////////////////////////
    // avalon cycle: request held until the rising edge at which waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wait_o !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // one external transfer; checks beats, lanes, column, strobe, spacing and pin quiet on a miss
    task automatic xfer(input logic [27:0] a, input logic w, input logic [1:0] sz, input int beats, step, gap,
        input logic [1:0] cm, input bit page, input bit drv);
        int n, k, last, hi, mv;
        logic [27:0] b;
        n = 0; k = 0; hi = 0; mv = 0; last = 0;
        @(posedge clk);
        m_a <= a; m_rw <= w; m_sz <= sz; go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (n < (beats > 0 ? 300 : 40) && !(k == beats && beats > 0 && ack_oe === 1'b0)) begin
            @(negedge clk);
            n++;
            if (ras !== 1'b1 || cas !== 2'h3 || ack_oe !== 1'b0 || a_oe !== 28'h0) mv = 1;
            if (ras === 1'b1 && k > 0 && k < beats) hi = 1;
            if (ack_oe === 1'b1 && ack_n === 1'b0) begin
                b = a + 28'(k * step);
                `CHK(cas, cm)
                `CHK(we_n, w)
                `CHK(ras, 1'b0)
                if (drv) `CHK(a_o, {10'h0, b[8:0], b[8:0]})
                `CHK(a_oe, drv ? 28'h0ffffff : 28'h0)
                if (k > 0) `CHK(n - last, gap)
                last = n;
                k++;
            end
        end
        `CHK(k, beats)
        if (beats == 0) `CHK(mv, 0)
        if (beats > 1) `CHK(hi, page ? 0 : 1)
        $display("transfer at %h done, %0d beats", a, k);
    endtask
    task automatic t_regs();
        bus(1'b0, 4'h0, 32'h0);
        `CHK(q, 32'h0)
        bus(1'b0, 4'hf, 32'h0);
        `CHK(q, 32'h0)
        bus(1'b1, 4'h0, 32'h8000);
        bus(1'b0, 4'h0, 32'h0);
        `CHK(q, 32'h8000)
        $display("register test done");
    endtask
    task automatic t_normal();
        bus(1'b1, 4'h4, 32'h05);
        xfer(28'h0000123, 1'b1, 2'h1, 1, 1, 4, 2'b10, 0, 1);
        bus(1'b1, 4'h4, 32'h09);
        xfer(28'h00001fe, 1'b0, 2'h0, 2, 2, 4, 2'b00, 0, 1);
        bus(1'b1, 4'h0, 32'h8060);
        xfer(28'h0000040, 1'b1, 2'h0, 2, 2, 7, 2'b00, 0, 1);
        $display("normal mode test done");
    endtask
    task automatic t_page();
        bus(1'b1, 4'h0, 32'h8000);
        bus(1'b1, 4'h4, 32'h06);
        xfer(28'h0000011, 1'b1, 2'h2, 2, 1, 2, 2'b10, 1, 1);
        xfer(28'h0000011, 1'b0, 2'h2, 2, 1, 2, 2'b10, 1, 1);
        xfer(28'h0000033, 1'b1, 2'h1, 1, 1, 2, 2'b10, 1, 1);
        bus(1'b1, 4'h4, 32'h03);
        xfer(28'h0000100, 1'b0, 2'h3, 4, 4, 2, 2'b00, 1, 1);
        $display("page mode test done");
    endtask
    task automatic t_miss_nodrive();
        // pins 27..24 not address: bit 24 counts as zero and still hits bank 0
        xfer(28'h1000000, 1'b1, 2'h0, 1, 4, 2, 2'b00, 1, 1);
        bus(1'b1, 4'h1, 32'hf);
        xfer(28'h1000000, 1'b1, 2'h0, 0, 4, 2, 2'b00, 1, 1);
        bus(1'b1, 4'h1, 32'h0);
        xfer(28'h0100000, 1'b1, 2'h0, 0, 4, 2, 2'b00, 1, 1);
        bus(1'b1, 4'h3, 32'hffffffff);
        xfer(28'h0100000, 1'b1, 2'h0, 1, 4, 2, 2'b00, 1, 1);
        bus(1'b1, 4'h0, 32'h0);
        xfer(28'h0000008, 1'b0, 2'h0, 1, 4, 2, 2'b00, 1, 0);
        $display("decode and drive test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard well past the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_normal();
        t_page();
        t_miss_nodrive();
        close_out();
    end
endmodule
`default_nettype wire
